// ==== src/phase_resync_serial_load.sv ====
// phase resync timer with three-wire serial latch loading and apb status
// Functional notes
// - while enabled, a sync pulse comes every interval x delay x comparator_period.
// - the interval count is the four-bit field 15..12 of the control latch, 1 to 15.
// - an interval count of zero, the reset value, disables timer and resync.
// - the delay multiplier is bits 13..3 of a modulus latch write with bit 23 set.
// - after a frequency commit the second following sync pulse realigns the phase.
// - data is shifted on each serial clock rise and moved to its latch on strobe rise.
// - the denominator accepts 2 to 4095, and no less than 50 with dither on.
`timescale 1ns/1ns
module phase_resync_serial_load
	import phase_resync_pkg::*;
(
	input wire logic CLK_SYS_I,
	input wire logic SYS_RST_I,
	input wire logic CE_I,
	input wire logic SCLK_I,
	input wire logic SDATA_I,
	input wire logic LATCH_STROBE_I,
	input wire apb_req_type APB_REQ_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic SYNC_PULSE_O,
	output logic PHASE_RESYNC_O
);
	// ****************************************************************
	// serial clock domain
	// ****************************************************************
	logic [WORD_BITS-1:0] shift_reg;

	// shifting never looks at the strobe, older bits fall off the top
	always_ff @(posedge SCLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			shift_reg <= LATCH_RESET;
		end else begin
			shift_reg <= {shift_reg[WORD_BITS-2:0], SDATA_I};
		end
	end

	// ****************************************************************
	// strobe synchroniser and word capture
	// ****************************************************************
	logic strobe_s1;
	logic strobe_s2;
	logic strobe_s3;
	wire strobe_rise = strobe_s2 & ~strobe_s3;
	// shift register is idle while strobe is high, so its word is stable here
	wire serial_word_type word_in = serial_word_type'(shift_reg);

	// two flops then an edge detector on the second
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			strobe_s1 <= 1'b0;
			strobe_s2 <= 1'b0;
			strobe_s3 <= 1'b0;
		end else if (CE_I) begin
			strobe_s1 <= LATCH_STROBE_I;
			strobe_s2 <= strobe_s1;
			strobe_s3 <= strobe_s2;
		end
	end

	// ****************************************************************
	// latch decode
	// ****************************************************************
	logic [23:0] control_latch;
	logic [23:0] modulus_latch;
	logic [23:0] frequency_latch;
	logic [3:0] interval;
	logic [10:0] delay_mult;
	logic [11:0] denominator;
	logic dither_en;
	logic reject_flag;

	wire commit = CE_I & strobe_rise;
	wire commit_ctrl = commit & (word_in.addr == ADDR_CONTROL);
	wire commit_modulus = commit & (word_in.addr == ADDR_MODULUS);
	wire commit_freq = commit & (word_in.addr == ADDR_FREQUENCY);
	wire load_sel = shift_reg[LOAD_SEL_BIT];
	wire [10:0] new_delay = shift_reg[DELAY_MSB:FIELD_LSB];
	wire [11:0] new_denom = shift_reg[DENOM_MSB:FIELD_LSB];
	// limit depends on dither mode
	wire denom_ok = (new_denom >= DENOM_MIN) &
		(~dither_en | (new_denom >= DENOM_MIN_DITHER));
	wire load_delay = commit_modulus & load_sel;
	wire load_denom = commit_modulus & ~load_sel & denom_ok;
	wire denom_bad = commit_modulus & ~load_sel & ~denom_ok;

	// whole latch words; control and frequency are read back, the modulus one is not
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			control_latch <= LATCH_RESET;
			modulus_latch <= LATCH_RESET;
			frequency_latch <= LATCH_RESET;
		end else begin
			if (commit_ctrl) control_latch <= shift_reg;
			if (commit_modulus & (load_sel | denom_ok)) modulus_latch <= shift_reg;
			if (commit_freq) frequency_latch <= shift_reg;
		end
	end

	// decoded fields; interval and delay multiplier steer the timer
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			interval <= INTERVAL_RESET;
			delay_mult <= DELAY_RESET;
			denominator <= DENOM_RESET;
		end else begin
			if (commit_ctrl) interval <= shift_reg[INTERVAL_MSB:INTERVAL_LSB];
			if (load_delay) delay_mult <= new_delay;
			if (load_denom) denominator <= new_denom;
		end
	end

	// ****************************************************************
	// sync timer
	// ****************************************************************
	logic [14:0] timer_count;
	wire [14:0] product = {11'h000, interval} * {4'h0, delay_mult};
	wire timer_en = (interval != INTERVAL_RESET) & (delay_mult != DELAY_RESET);
	wire timer_hit = timer_en & (timer_count == (product - 15'h0001));
	wire [14:0] next_count = (timer_hit | ~timer_en) ? 15'h0000 : timer_count + 15'h0001;

	// counts reference cycles and restarts at zero on the hit
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			timer_count <= 15'h0000;
			SYNC_PULSE_O <= 1'b0;
		end else if (CE_I) begin
			timer_count <= next_count;
			SYNC_PULSE_O <= timer_hit;
		end
	end

	// ****************************************************************
	// resync arming
	// ****************************************************************
	arm_state_type arm_state;
	arm_state_type next_arm;
	logic [15:0] resync_count;
	wire resync_fire = (arm_state == ARM_SECOND) & timer_hit & ~commit_freq;

	// a new commit restarts the count of pulses, even on a hit cycle
	always_comb begin
		next_arm = arm_state;
		if (~timer_en) begin
			next_arm = ARM_IDLE;
		end else if (commit_freq) begin
			next_arm = ARM_FIRST;
		end else if (timer_hit) begin
			case (arm_state)
				ARM_FIRST: next_arm = ARM_SECOND; // first pulse only counted
				ARM_SECOND: next_arm = ARM_IDLE;
				ARM_IDLE: next_arm = ARM_IDLE;
				default: next_arm = ARM_IDLE;
			endcase
		end
	end

	// resync output and running total for software
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			arm_state <= ARM_IDLE;
			PHASE_RESYNC_O <= 1'b0;
			resync_count <= 16'h0000;
		end else if (CE_I) begin
			arm_state <= next_arm;
			PHASE_RESYNC_O <= resync_fire & timer_en;
			if (resync_fire & timer_en) resync_count <= resync_count + 16'h0001;
		end
	end

	// ****************************************************************
	// apb slave
	// ****************************************************************
	wire apb_access = APB_REQ_I.psel & APB_REQ_I.penable;
	wire apb_done = apb_access & PREADY_O;
	wire [7:0] ofs = APB_REQ_I.paddr;
	wire hit_config = (ofs == OFS_CONFIG);
	wire hit_status = (ofs == OFS_STATUS);
	wire mapped = hit_config | hit_status | (ofs == OFS_CONTROL_LATCH) |
		(ofs == OFS_MODULUS_LATCH) | (ofs == OFS_FREQUENCY_LATCH) |
		(ofs == OFS_RESYNC_COUNT);
	wire wr_config = apb_done & APB_REQ_I.pwrite & hit_config;
	wire wr_status = apb_done & APB_REQ_I.pwrite & hit_status;
	wire clear_reject = wr_status & APB_REQ_I.pwdata[STS_REJECT_BIT];
	wire [31:0] status_word = {27'h0000000, timer_en, arm_state != ARM_IDLE,
		arm_state == ARM_SECOND, 1'b0, reject_flag};
	logic [31:0] read_mux;

	// read data select
	always_comb begin
		case (ofs)
			OFS_CONFIG: read_mux = {31'h00000000, dither_en};
			OFS_STATUS: read_mux = status_word;
			OFS_CONTROL_LATCH: read_mux = {8'h00, control_latch};
			OFS_MODULUS_LATCH: read_mux = {4'h0, denominator, 5'h00, delay_mult};
			OFS_FREQUENCY_LATCH: read_mux = {8'h00, frequency_latch};
			OFS_RESYNC_COUNT: read_mux = {16'h0000, resync_count};
			default: read_mux = 32'h00000000;
		endcase
	end

	// one wait state, answer registered at the edge that raises pready
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= 32'h00000000;
			PSLVERR_O <= 1'b0;
		end else if (CE_I) begin
			PREADY_O <= apb_access & ~PREADY_O;
			PRDATA_O <= (apb_access & ~PREADY_O & ~APB_REQ_I.pwrite) ? read_mux : 32'h00000000;
			PSLVERR_O <= apb_access & ~PREADY_O & ~mapped;
		end
	end

	// config bit and sticky reject flag, a new reject beats the clear
	always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			dither_en <= CONFIG_RESET;
			reject_flag <= 1'b0;
		end else if (CE_I) begin
			if (wr_config) dither_en <= APB_REQ_I.pwdata[CFG_DITHER_BIT];
			reject_flag <= denom_bad | (reject_flag & ~clear_reject);
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	a_shift_sample: assert property (@(posedge SCLK_I) disable iff (SYS_RST_I)
		shift_reg[0] == $past(SDATA_I))
		else $error("shift register missed serial bit");
	a_no_latch_low: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		!strobe_rise |=> $stable(control_latch) && $stable(frequency_latch))
		else $error("latch changed without strobe rise");
	a_interval_load: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		commit_ctrl |=> interval == $past(shift_reg[15:12]))
		else $error("interval field not loaded");
	a_delay_load: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		load_delay |=> delay_mult == $past(new_delay) && $stable(denominator))
		else $error("delay multiplier load wrong");
	a_denom_guard: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		denom_bad |=> $stable(denominator) && reject_flag)
		else $error("bad denominator accepted");
	a_disabled_quiet: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		interval == INTERVAL_RESET |=> !SYNC_PULSE_O && !PHASE_RESYNC_O)
		else $error("timer active while disabled");
	a_pulse_width: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		SYNC_PULSE_O && product > 15'h0001 && $stable(product) |-> ##1 !SYNC_PULSE_O)
		else $error("sync pulse longer than one cycle");
	a_pulse_period: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		timer_en && timer_count == product - 15'h0001 |=> SYNC_PULSE_O && timer_count == 15'h0000)
		else $error("sync pulse not at programmed product");
	a_second_pulse: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		PHASE_RESYNC_O |-> SYNC_PULSE_O && $past(arm_state) == ARM_SECOND)
		else $error("resync not on second sync pulse");
	a_first_skipped: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		arm_state == ARM_FIRST && timer_hit && !commit_freq |=> !PHASE_RESYNC_O)
		else $error("resync on first sync pulse");
	a_apb_wait: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I || !CE_I)
		apb_access && !PREADY_O |=> PREADY_O)
		else $error("apb answer late");

	// apb answer shape, config write and reject clear
	a_ready_single: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I || !CE_I)
		PREADY_O |=> !PREADY_O)
		else $error("pready longer than one cycle");
	a_slverr_ready: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		PSLVERR_O |-> PREADY_O)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		!PREADY_O |-> PRDATA_O == 32'h00000000)
		else $error("read data outside answer cycle");
	a_dither_write: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		wr_config |=> dither_en == $past(APB_REQ_I.pwdata[CFG_DITHER_BIT]))
		else $error("dither bit not written");
	a_reject_clear: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		clear_reject && !denom_bad |=> !reject_flag)
		else $error("reject flag not cleared");

	// latch words follow the strobe
	a_freq_commit: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		commit_freq |=> frequency_latch == $past(shift_reg))
		else $error("frequency latch not loaded");
	a_ctrl_commit: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		commit_ctrl |=> control_latch == $past(shift_reg))
		else $error("control latch not loaded");

	// timer and arming when off or rearmed, and the resync total
	a_count_reset: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		!timer_en |=> timer_count == 15'h0000)
		else $error("timer count not held at zero");
	a_delay_quiet: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		delay_mult == DELAY_RESET |=> !SYNC_PULSE_O)
		else $error("sync pulse with zero delay");
	a_arm_disabled: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I || !CE_I)
		!timer_en |=> arm_state == ARM_IDLE)
		else $error("resync armed while disabled");
	a_arm_commit: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		commit_freq && timer_en |=> arm_state == ARM_FIRST)
		else $error("frequency commit did not rearm");
	a_resync_total: assert property (@(posedge CLK_SYS_I)
		disable iff (SYS_RST_I)
		PHASE_RESYNC_O |-> resync_count == $past(resync_count) + 16'h0001)
		else $error("resync count not advanced");

	// scenarios worth seeing
	c_resync_seen: cover property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		commit_freq ##[1:1000] PHASE_RESYNC_O);
	c_denom_reject: cover property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) denom_bad);
	c_delay_loaded: cover property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		load_delay ##[1:300] SYNC_PULSE_O);
	c_dither_load: cover property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
		dither_en && load_denom);
	c_apb_error: cover property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) PSLVERR_O);
endmodule // phase_resync_serial_load

// ==== src/phase_resync_pkg.sv ====
// shared constants and carriers of the phase resync serial load block
package phase_resync_pkg;
	// ****************************************************************
	// serial word layout
	// ****************************************************************
	localparam int WORD_BITS = 24;
	localparam int ADDR_MSB = 1;
	localparam logic [1:0] ADDR_FREQUENCY = 2'h0;
	localparam logic [1:0] ADDR_MODULUS = 2'h1;
	localparam logic [1:0] ADDR_CONTROL = 2'h2;
	localparam int INTERVAL_MSB = 15;
	localparam int INTERVAL_LSB = 12;
	localparam int DELAY_MSB = 13;
	localparam int DENOM_MSB = 14;
	localparam int FIELD_LSB = 3;
	localparam int LOAD_SEL_BIT = 23;
	// ****************************************************************
	// reset values and limits
	// ****************************************************************
	localparam logic [23:0] LATCH_RESET = 24'h000000;
	localparam logic [3:0] INTERVAL_RESET = 4'h0;
	localparam logic [10:0] DELAY_RESET = 11'h000;
	localparam logic [11:0] DENOM_RESET = 12'h002;
	localparam logic [11:0] DENOM_MIN = 12'h002;
	localparam logic [11:0] DENOM_MIN_DITHER = 12'h032;
	// ****************************************************************
	// apb register map
	// ****************************************************************
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CONTROL_LATCH = 8'h08;
	localparam logic [7:0] OFS_MODULUS_LATCH = 8'h0C;
	localparam logic [7:0] OFS_FREQUENCY_LATCH = 8'h10;
	localparam logic [7:0] OFS_RESYNC_COUNT = 8'h14;
	localparam int CFG_DITHER_BIT = 0;
	localparam int STS_REJECT_BIT = 0;
	localparam logic CONFIG_RESET = 1'h0;
	// ****************************************************************
	// carriers and states
	// ****************************************************************
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;
	typedef struct packed {
		logic [21:0] payload;
		logic [1:0] addr;
	} serial_word_type;
	typedef enum logic [1:0] {ARM_IDLE, ARM_FIRST, ARM_SECOND} arm_state_type;
endpackage

// ==== bench/serial_host_model.sv ====
// host serial master model: shifts words msb first and strobes them in
`timescale 1ns/1ns
module serial_host_model
	import phase_resync_pkg::*;
(
	input wire logic go_i,
	input wire logic [31:0] word_i,
	input wire logic [5:0] nbits_i,
	output logic busy_o,
	output logic sclk_o,
	output logic sdata_o,
	output logic latch_strobe_o
);
	// start: clock low, strobe low, data low until the first frame
	initial begin
		busy_o = 1'b0;
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		latch_strobe_o = 1'b0;
	end
	// one frame per go rise, 64 ns serial period, clock still between frames
	always @(posedge go_i) begin : frame
		int i;
		busy_o = 1'b1;
		#7 latch_strobe_o = 1'b0;
		#32;
		for (i = int'(nbits_i) - 1; i >= 0; i--) begin
			sdata_o = word_i[i];
			#32 sclk_o = 1'b1;
			#32 sclk_o = 1'b0;
		end
		sdata_o = ~sdata_o; // released line shows no stale bit
		#32 latch_strobe_o = 1'b1;
		#400 busy_o = 1'b0; // strobe stays high well over four system cycles
	end
endmodule // serial_host_model

// ==== bench/phase_resync_serial_load_tb_top.sv ====
// testbench of the phase resync serial load block
`timescale 1ns/1ns
module phase_resync_serial_load_tb_top
	import phase_resync_pkg::*;
;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	apb_req_type apb_req = '0;
	logic go = 1'b0;
	logic [31:0] word = 32'h00000000;
	logic [5:0] nbits = 6'h18;
	logic busy, sclk, sdata, strobe, pready, pslverr, sync_pulse, resync;
	logic [31:0] prdata;
	int bad_count = 0;
	int checks_done = 0;
	always #25 clk_sys = ~clk_sys;
	phase_resync_serial_load u_phase_resync_serial_load (.CLK_SYS_I(clk_sys), .SYS_RST_I(sys_rst),
		.CE_I(1'b1), .SCLK_I(sclk), .SDATA_I(sdata), .LATCH_STROBE_I(strobe),
		.APB_REQ_I(apb_req), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.SYNC_PULSE_O(sync_pulse), .PHASE_RESYNC_O(resync));
	serial_host_model u_serial_host_model (.go_i(go), .word_i(word), .nbits_i(nbits),
		.busy_o(busy), .sclk_o(sclk), .sdata_o(sdata), .latch_strobe_o(strobe));
	// ****************************************************************
	// checking and bus tasks
	// ****************************************************************
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clk_sys);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) chk("pready wait", 1, 0);
		rd = prdata;
		er = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] mask, input logic err);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 32'h00000000, d, e);
		chk(w, exp, d & mask);
		chk("pslverr", {31'h0, err}, {31'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		logic e;
		apb(1'b1, a, wd, d, e);
	endtask
	// one serial frame through the host model, bounded wait
	task automatic send(input logic [31:0] w, input logic [5:0] n);
		int k;
		word <= w;
		nbits <= n;
		go <= 1'b1;
		repeat (2) @(posedge clk_sys);
		go <= 1'b0;
		for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk_sys);
		chk("frame done", 0, {31'h0, busy});
	endtask
	// cycles between two sync pulses
	task automatic sync_gap(input int exp);
		int k, g;
		g = 0;
		for (k = 0; k < 300 && sync_pulse !== 1'b1; k++) @(posedge clk_sys);
		do begin
			@(posedge clk_sys);
			g++;
		end while (sync_pulse !== 1'b1 && g < 300);
		chk("sync gap", 32'(exp), 32'(g));
	endtask
	task automatic resync_chk;
		int k, s;
		s = 0;
		// start after the commit edge, three cycles past the strobe rise
		while (strobe !== 1'b0) @(posedge clk_sys);
		while (strobe !== 1'b1) @(posedge clk_sys);
		repeat (3) @(posedge clk_sys);
		for (k = 0; k < 300 && resync !== 1'b1; k++) begin
			@(posedge clk_sys);
			if (sync_pulse === 1'b1) s++;
		end
		chk("sync pulses to resync", 2, 32'(s));
		chk("resync on sync", 1, {31'h0, sync_pulse});
	endtask
	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin : tests
		int k, s;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd_chk("status", OFS_STATUS, 32'h0, 32'hFFFFFFFF, 1'b0);
		rd_chk("modulus", OFS_MODULUS_LATCH, 32'h00020000, 32'hFFFFFFFF, 1'b0);
		rd_chk("unmapped", 8'h18, 32'h0, 32'hFFFFFFFF, 1'b1);
		wr(OFS_CONTROL_LATCH, 32'h00FFFFFF);
		rd_chk("ro control", OFS_CONTROL_LATCH, 32'h0, 32'hFFFFFFFF, 1'b0);
		send(32'h00800021, 6'h18);
		rd_chk("delay", OFS_MODULUS_LATCH, 32'h00020004, 32'hFFFFFFFF, 1'b0);
		send(32'h00001002, 6'h18);
		rd_chk("control", OFS_CONTROL_LATCH, 32'h00001002, 32'hFFFFFFFF, 1'b0);
		sync_gap(4);
		send(32'h0000F002, 6'h18);
		sync_gap(60);
		fork
			send(32'h00123450, 6'h18);
			resync_chk();
		join
		rd_chk("frequency", OFS_FREQUENCY_LATCH, 32'h00123450, 32'hFFFFFFFF, 1'b0);
		rd_chk("resync count", OFS_RESYNC_COUNT, 32'h1, 32'h0000FFFF, 1'b0);
		send(32'h00000009, 6'h18);
		rd_chk("reject", OFS_STATUS, 32'h1, 32'h1, 1'b0);
		rd_chk("kept modulus", OFS_MODULUS_LATCH, 32'h00020004, 32'hFFFFFFFF, 1'b0);
		wr(OFS_STATUS, 32'h1);
		rd_chk("reject clear", OFS_STATUS, 32'h0, 32'h1, 1'b0);
		// timer off before the denominator moves away from the delay multiple
		send(32'hF0000002, 6'h1C);
		rd_chk("last 24", OFS_CONTROL_LATCH, 32'h00000002, 32'hFFFFFFFF, 1'b0);
		rd_chk("timer off", OFS_STATUS, 32'h0, 32'h10, 1'b0);
		wr(OFS_CONFIG, 32'h1);
		send(32'h00000189, 6'h18);
		rd_chk("dither reject", OFS_STATUS, 32'h1, 32'h1, 1'b0);
		send(32'h00000191, 6'h18);
		rd_chk("dither min", OFS_MODULUS_LATCH, 32'h00320004, 32'hFFFFFFFF, 1'b0);
		s = 0;
		for (k = 0; k < 100; k++) begin
			@(posedge clk_sys);
			if (sync_pulse !== 1'b0) s++;
		end
		chk("idle sync", 0, 32'(s));
		end_of_test();
	end
	// watchdog against a hang
	initial begin
		#500000;
		bad_count++;
		end_of_test();
	end
endmodule // phase_resync_serial_load_tb_top
